// >>> rtl/bfg_guard.sv
// Boot flash section guard: self-programming access control and CPU halt
//
// The address-and-strobe port and the register offsets were decided locally.
`timescale 1ns/100ps
`default_nettype none
module bfg_guard
	import bfg_pkg::*;
(
	// Clock and reset
	input wire logic mclk,
	input wire logic arst_n,
	// Fuses and nonvolatile lock image
	input wire logic [1:0] bootSizeFuses,
	input wire logic [3:0] lockNv,
	input wire logic vecInBoot,
	// Serial or parallel programming lock access
	input wire logic chipErase,
	input wire logic progLockWr,
	input wire logic [3:0] progLockData,
	// CPU store and load requests
	input wire bfg_spm_req_t store_program_memory_instr,
	input wire logic lpmReq,
	input wire logic [BFG_AW-1:0] lpmPc,
	input wire logic [BFG_AW-1:0] lpmAddr,
	input wire logic [BFG_AW-1:0] curPc,
	// Flash array
	input wire logic flashDone,
	output logic flashStart,
	output logic flashErase,
	output logic [BFG_PG_AW-1:0] flashPage,
	// CPU controls
	output logic cpuHalt,
	output logic rwwBlock,
	output logic lpmGrant,
	output logic lpmDeny,
	output logic intDisable,
	output logic irq,
	// Register port
	input wire logic [3:0] regAddr,
	input wire logic [7:0] regWdata,
	input wire logic regWr,
	input wire logic regRd,
	output logic [7:0] regRdata
);
	bfg_regs_t r;
	bfg_regs_t next_r;
	logic [BFG_AW:0] bootWords;
	logic [BFG_AW-1:0] rawStart;
	logic [BFG_AW-1:0] bootStart;
	logic spmInApp;
	logic tgtInApp;
	logic tgtInRww;
	logic wrLocked;
	logic lpmBlocked;
	logic [BFG_NEV-1:0] ev;

	// Section boundary from the fuses, clamped into the stalling region
	always_comb begin
		bootWords = BFG_BOOT_MIN_WORDS << (~bootSizeFuses);
		rawStart = BFG_AW'(~bootWords[BFG_AW-1:0] + 1'b1);
		bootStart = (rawStart < BFG_STALLING_REGION_START) ? BFG_STALLING_REGION_START : rawStart;
	end

	// Request classification
	always_comb begin
		spmInApp = store_program_memory_instr.pc < bootStart;
		tgtInApp = store_program_memory_instr.addr < bootStart;
		tgtInRww = store_program_memory_instr.addr < BFG_STALLING_REGION_START;
		// General lock modes are not inputs here, so they never restrict stores or loads
		wrLocked = tgtInApp ? !r.lock[BFG_APP_B1] : !r.lock[BFG_BOOT_B1];
		if (lpmPc >= bootStart && lpmAddr < bootStart) begin
			lpmBlocked = !r.lock[BFG_APP_B2];
		end else if (lpmPc < bootStart && lpmAddr >= bootStart) begin
			lpmBlocked = !r.lock[BFG_BOOT_B2];
		end else begin
			lpmBlocked = 1'b0;
		end
		if (r.rwwBusy && lpmAddr < BFG_STALLING_REGION_START) begin
			lpmBlocked = 1'b1;
		end
	end

	// Next state
	always_comb begin
		next_r = r;
		ev = '0;
		next_r.flashStart = 1'b0;
		next_r.lpmOk = 1'b0;
		next_r.lpmNo = 1'b0;
		next_r.rdata = BFG_RD_ZERO;
		// Lock image is taken once after reset release
		if (!r.lockLoaded) begin
			next_r.lock = lockNv;
			next_r.lockLoaded = 1'b1;
		end
		// Store requests
		if (store_program_memory_instr.valid && r.lockLoaded) begin
			if (spmInApp) begin
				ev[BFG_EV_APPSPM] = 1'b1;
			end else if (store_program_memory_instr.op == BFG_OP_LOCKSET) begin
				next_r.lock = r.lock & store_program_memory_instr.lockData;
			end else if ((store_program_memory_instr.op == BFG_OP_ERASE || store_program_memory_instr.op == BFG_OP_WRITE) && r.st == BFG_IDLE) begin
				if (wrLocked) begin
					ev[BFG_EV_LOCKED] = 1'b1;
				end else begin
					// Any page of the whole array is accepted from boot code
					next_r.page = store_program_memory_instr.addr[BFG_AW-1:BFG_PAGE_W];
					next_r.erase = store_program_memory_instr.op == BFG_OP_ERASE;
					next_r.flashStart = 1'b1;
					if (tgtInRww) begin
						next_r.st = BFG_RWW;
						next_r.rwwBusy = 1'b1;
					end else begin
						next_r.st = BFG_HALT;
						next_r.halt = 1'b1;
					end
				end
			end
		end
		// Programming-mode lock writes only program bits
		if (progLockWr) begin
			next_r.lock = next_r.lock & progLockData;
		end
		if (chipErase) begin
			next_r.lock = BFG_LOCK_ERASED;
		end
		// Operation end
		case (r.st)
			BFG_RWW: begin
				if (flashDone) begin
					next_r.st = BFG_IDLE;
					ev[BFG_EV_DONE] = 1'b1;
				end
			end
			BFG_HALT: begin
				if (flashDone) begin
					next_r.st = BFG_IDLE;
					next_r.halt = 1'b0;
					ev[BFG_EV_DONE] = 1'b1;
				end
			end
			default: begin
				next_r.st = next_r.st;
			end
		endcase
		// Program-memory reads
		if (lpmReq) begin
			next_r.lpmOk = !lpmBlocked;
			next_r.lpmNo = lpmBlocked;
			ev[BFG_EV_LPMDENY] = lpmBlocked;
		end
		// Interrupt masking while executing from a read-protected section
		next_r.intDis = (!r.lock[BFG_APP_B2] && vecInBoot && curPc < bootStart)
			|| (!r.lock[BFG_BOOT_B2] && !vecInBoot && curPc >= bootStart);
		// Register writes
		if (regWr) begin
			if (regAddr == BFG_REG_CTRL) begin
				// Busy flag cleared only when idle; a start in the same cycle wins
				if (regWdata[BFG_CTRL_REEN] && r.st == BFG_IDLE && next_r.st == BFG_IDLE) begin
					next_r.rwwBusy = 1'b0;
				end
			end else if (regAddr == BFG_REG_IRQ_CLR) begin
				next_r.irqStat = r.irqStat & ~regWdata[BFG_NEV-1:0];
			end else if (regAddr == BFG_REG_IRQ_EN) begin
				next_r.irqEn = regWdata[BFG_NEV-1:0];
			end
		end
		// Events win over a clear in the same cycle
		next_r.irqStat = next_r.irqStat | ev;
		next_r.irq = |(next_r.irqStat & next_r.irqEn);
		// Register reads
		if (regRd) begin
			if (regAddr == BFG_REG_STATUS) begin
				next_r.rdata = {r.lock, 1'b0, r.st != BFG_IDLE, r.halt, r.rwwBusy};
			end else if (regAddr == BFG_REG_IRQ_STAT) begin
				next_r.rdata = {{(8-BFG_NEV){1'b0}}, r.irqStat};
			end else if (regAddr == BFG_REG_IRQ_EN) begin
				next_r.rdata = {{(8-BFG_NEV){1'b0}}, r.irqEn};
			end else begin
				next_r.rdata = BFG_RD_ZERO;
			end
		end
	end

	// State register
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			r <= '{st: BFG_IDLE, lock: BFG_LOCK_ERASED, default: '0};
		end else begin
			r <= next_r;
		end
	end

	// Outputs straight from the state register
	assign flashStart = r.flashStart;
	assign flashErase = r.erase;
	assign flashPage = r.page;
	assign cpuHalt = r.halt;
	assign rwwBlock = r.rwwBusy;
	assign lpmGrant = r.lpmOk;
	assign lpmDeny = r.lpmNo;
	assign intDisable = r.intDis;
	assign irq = r.irq;
	assign regRdata = r.rdata;

	// Checks
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!arst_n);

	property p_app_spm_ignored;
		store_program_memory_instr.valid && spmInApp |=> !flashStart;
	endproperty
	a_app_spm_ignored: assert property (p_app_spm_ignored) else $error("store from application started flash");

	property p_boot_spm_any;
		store_program_memory_instr.valid && r.lockLoaded && !spmInApp && store_program_memory_instr.op == BFG_OP_ERASE && r.st == BFG_IDLE && !wrLocked
			|=> flashStart && flashErase && flashPage == $past(store_program_memory_instr.addr[BFG_AW-1:BFG_PAGE_W]);
	endproperty
	a_boot_spm_any: assert property (p_boot_spm_any) else $error("boot store did not start erase");

	property p_rww_runs;
		flashStart && r.st == BFG_RWW |-> !cpuHalt && rwwBlock;
	endproperty
	a_rww_runs: assert property (p_rww_runs) else $error("concurrent op halted or unblocked");

	property p_halt_whole;
		r.st == BFG_HALT && !flashDone |=> cpuHalt && r.st == BFG_HALT;
	endproperty
	a_halt_whole: assert property (p_halt_whole) else $error("halt dropped before done");

	property p_halt_release;
		r.st == BFG_HALT && flashDone |=> !cpuHalt;
	endproperty
	a_halt_release: assert property (p_halt_release) else $error("halt held after done");

	property p_rww_lpm_blocked;
		rwwBlock && lpmReq && lpmAddr < BFG_STALLING_REGION_START |=> lpmDeny && !lpmGrant;
	endproperty
	a_rww_lpm_blocked: assert property (p_rww_lpm_blocked) else $error("blocked region was read");

	property p_flag_read;
		regRd && regAddr == BFG_REG_STATUS |=> regRdata[0] == $past(rwwBlock);
	endproperty
	a_flag_read: assert property (p_flag_read) else $error("busy flag read wrong");

	property p_boot_in_stalling_region;
		bootStart >= BFG_STALLING_REGION_START;
	endproperty
	a_boot_in_stalling_region: assert property (p_boot_in_stalling_region) else $error("boot section leaves stalling region");

	property p_lock_unprogram;
		r.lockLoaded && $past(r.lockLoaded) && (r.lock & ~$past(r.lock)) != 4'h0 |-> $past(chipErase);
	endproperty
	a_lock_unprogram: assert property (p_lock_unprogram) else $error("lock bit cleared without erase");

	property p_app_read_lock;
		lpmReq && lpmPc >= bootStart && lpmAddr < bootStart && !r.lock[BFG_APP_B2] |=> lpmDeny;
	endproperty
	a_app_read_lock: assert property (p_app_read_lock) else $error("protected application read allowed");

	property p_app_int;
		!r.lock[BFG_APP_B2] && vecInBoot && curPc < bootStart && !chipErase && !progLockWr |=> intDisable;
	endproperty
	a_app_int: assert property (p_app_int) else $error("interrupts not masked in application");

	property p_locked_noop;
		store_program_memory_instr.valid && r.lockLoaded && !spmInApp && store_program_memory_instr.op != BFG_OP_LOCKSET && store_program_memory_instr.op != BFG_OP_OTHER
			&& r.st == BFG_IDLE && wrLocked |=> !flashStart && r.st == BFG_IDLE && !cpuHalt;
	endproperty
	a_locked_noop: assert property (p_locked_noop) else $error("locked write started");

	// Further checks on boundaries, locks, events and the register port
	property p_fuse_boundary;
		{1'b0, bootStart} + (BFG_BOOT_MIN_WORDS << (~bootSizeFuses)) == {1'b1, {BFG_AW{1'b0}}};
	endproperty
	a_fuse_boundary: assert property (p_fuse_boundary) else $error("boot size does not follow fuses");

	property p_boot_read_lock;
		lpmReq && lpmPc < bootStart && lpmAddr >= bootStart && !r.lock[BFG_BOOT_B2] |=> lpmDeny;
	endproperty
	a_boot_read_lock: assert property (p_boot_read_lock) else $error("protected boot read allowed");

	property p_boot_int;
		!r.lock[BFG_BOOT_B2] && !vecInBoot && curPc >= bootStart |=> intDisable;
	endproperty
	a_boot_int: assert property (p_boot_int) else $error("interrupts not masked in boot");

	property p_lpm_one;
		lpmReq |=> lpmGrant != lpmDeny;
	endproperty
	a_lpm_one: assert property (p_lpm_one) else $error("load answer not exactly one");

	property p_target_split;
		store_program_memory_instr.valid && r.lockLoaded && !spmInApp && (store_program_memory_instr.op == BFG_OP_ERASE || store_program_memory_instr.op == BFG_OP_WRITE)
			&& r.st == BFG_IDLE && !wrLocked |=> cpuHalt == ($past(store_program_memory_instr.addr) >= BFG_STALLING_REGION_START) && r.st != BFG_IDLE;
	endproperty
	a_target_split: assert property (p_target_split) else $error("halt choice ignores target page");

	property p_halt_state;
		cpuHalt == (r.st == BFG_HALT);
	endproperty
	a_halt_state: assert property (p_halt_state) else $error("halt outside stalling operation");

	property p_rww_busy;
		r.st == BFG_RWW |-> rwwBlock;
	endproperty
	a_rww_busy: assert property (p_rww_busy) else $error("region readable while programmed");

	property p_flag_holds;
		rwwBlock && !(regWr && regAddr == BFG_REG_CTRL && regWdata[BFG_CTRL_REEN]) |=> rwwBlock;
	endproperty
	a_flag_holds: assert property (p_flag_holds) else $error("busy flag dropped by itself");

	property p_flag_clear;
		rwwBlock && r.st == BFG_IDLE && !store_program_memory_instr.valid && regWr && regAddr == BFG_REG_CTRL && regWdata[BFG_CTRL_REEN]
			|=> !rwwBlock;
	endproperty
	a_flag_clear: assert property (p_flag_clear) else $error("busy flag not cleared when idle");

	property p_busy_set;
		flashStart && !cpuHalt |-> rwwBlock;
	endproperty
	a_busy_set: assert property (p_busy_set) else $error("concurrent start left region open");

	property p_rdata_idle;
		!regRd |=> regRdata == BFG_RD_ZERO;
	endproperty
	a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside answer cycle");

	property p_app_event;
		store_program_memory_instr.valid && r.lockLoaded && spmInApp |=> r.irqStat[BFG_EV_APPSPM];
	endproperty
	a_app_event: assert property (p_app_event) else $error("ignored store not flagged");

	property p_locked_event;
		store_program_memory_instr.valid && r.lockLoaded && !spmInApp && (store_program_memory_instr.op == BFG_OP_ERASE || store_program_memory_instr.op == BFG_OP_WRITE)
			&& r.st == BFG_IDLE && wrLocked |=> r.irqStat[BFG_EV_LOCKED];
	endproperty
	a_locked_event: assert property (p_locked_event) else $error("locked store not flagged");

	property p_done_event;
		r.st != BFG_IDLE && flashDone |=> r.st == BFG_IDLE && r.irqStat[BFG_EV_DONE];
	endproperty
	a_done_event: assert property (p_done_event) else $error("operation end not flagged");

	property p_deny_event;
		lpmDeny |-> r.irqStat[BFG_EV_LPMDENY];
	endproperty
	a_deny_event: assert property (p_deny_event) else $error("denied load not flagged");

	property p_boot_write_lock;
		store_program_memory_instr.valid && r.lockLoaded && !spmInApp && store_program_memory_instr.op != BFG_OP_LOCKSET && store_program_memory_instr.addr >= bootStart
			&& !r.lock[BFG_BOOT_B1] |=> !flashStart;
	endproperty
	a_boot_write_lock: assert property (p_boot_write_lock) else $error("locked boot page programmed");

	property p_app_write_lock;
		store_program_memory_instr.valid && r.lockLoaded && !spmInApp && store_program_memory_instr.op != BFG_OP_LOCKSET && store_program_memory_instr.addr < bootStart
			&& !r.lock[BFG_APP_B1] |=> !flashStart;
	endproperty
	a_app_write_lock: assert property (p_app_write_lock) else $error("locked application page programmed");

	property p_lockset;
		store_program_memory_instr.valid && r.lockLoaded && !spmInApp && store_program_memory_instr.op == BFG_OP_LOCKSET && !chipErase
			|=> (r.lock & ~$past(store_program_memory_instr.lockData)) == 4'h0;
	endproperty
	a_lockset: assert property (p_lockset) else $error("lock set from software not applied");

	property p_chip_erase;
		chipErase |=> r.lock == BFG_LOCK_ERASED;
	endproperty
	a_chip_erase: assert property (p_chip_erase) else $error("chip erase left locks programmed");

	c_rww_op: cover property (flashStart && r.st == BFG_RWW ##[1:100] flashDone);
	c_halt_op: cover property (flashStart && r.st == BFG_HALT ##[1:100] !cpuHalt);
	c_locked: cover property (r.irqStat[BFG_EV_LOCKED]);
	c_lpm_deny: cover property (lpmDeny);
	c_int_masked: cover property (intDisable);
endmodule
`default_nettype wire

// >>> rtl/bfg_pkg.sv
// Constants, types and register map of the boot flash section guard
// How it works
// - Store from application code is ignored
// - Boot code may program any page
// - Boot size fuses set section boundary
// - Concurrent-region programming keeps CPU running
// - Stalling-region programming halts CPU throughout
// - Concurrent region read-blocked while programming
// - Busy flag reads one while blocked
// - Boot section always inside stalling region
// - Lock bits only cleared by chip erase
// - General write lock ignored by store
// - General read/write lock ignored by loads/stores
// - Application lock field gates writes and reads
// - Application lock disables interrupts in application when vectors are in boot
// - Boot lock field gates writes and reads
// - Boot lock disables interrupts in boot when vectors are in application
`default_nettype none
package bfg_pkg;
	localparam int BFG_AW = 16;
	localparam int BFG_PAGE_W = 7;
	localparam int BFG_PG_AW = BFG_AW - BFG_PAGE_W;
	localparam logic [BFG_AW-1:0] BFG_STALLING_REGION_START = 16'hF000;
	localparam logic [BFG_AW:0] BFG_BOOT_MIN_WORDS = 17'h00200;
	// Lock register bit positions
	localparam int BFG_APP_B1 = 0;
	localparam int BFG_APP_B2 = 1;
	localparam int BFG_BOOT_B1 = 2;
	localparam int BFG_BOOT_B2 = 3;
	localparam logic [3:0] BFG_LOCK_ERASED = 4'hF;
	// Register offsets
	localparam logic [3:0] BFG_REG_CTRL = 4'h0;
	localparam logic [3:0] BFG_REG_STATUS = 4'h1;
	localparam logic [3:0] BFG_REG_IRQ_STAT = 4'h2;
	localparam logic [3:0] BFG_REG_IRQ_CLR = 4'h3;
	localparam logic [3:0] BFG_REG_IRQ_EN = 4'h4;
	localparam int BFG_CTRL_REEN = 0;
	// Interrupt event bits
	localparam int BFG_EV_DONE = 0;
	localparam int BFG_EV_LOCKED = 1;
	localparam int BFG_EV_APPSPM = 2;
	localparam int BFG_EV_LPMDENY = 3;
	localparam int BFG_NEV = 4;
	localparam logic [7:0] BFG_RD_ZERO = 8'h00;

	typedef enum logic [2:0] {
		BFG_IDLE = 3'b001,
		BFG_RWW = 3'b010,
		BFG_HALT = 3'b100
	} bfg_state_t;

	typedef enum logic [1:0] {
		BFG_OP_OTHER = 2'h0,
		BFG_OP_ERASE = 2'h1,
		BFG_OP_WRITE = 2'h2,
		BFG_OP_LOCKSET = 2'h3
	} bfg_op_t;

	// Store-program-memory request from the CPU
	typedef struct packed {
		logic valid;
		bfg_op_t op;
		logic [BFG_AW-1:0] pc;
		logic [BFG_AW-1:0] addr;
		logic [3:0] lockData;
	} bfg_spm_req_t;

	// Complete state of the guard
	typedef struct packed {
		bfg_state_t st;
		logic [BFG_PG_AW-1:0] page;
		logic erase;
		logic flashStart;
		logic rwwBusy;
		logic halt;
		logic [3:0] lock;
		logic lockLoaded;
		logic intDis;
		logic lpmOk;
		logic lpmNo;
		logic [BFG_NEV-1:0] irqStat;
		logic [BFG_NEV-1:0] irqEn;
		logic irq;
		logic [7:0] rdata;
	} bfg_regs_t;
endpackage
`default_nettype wire

// >>> tb/bfg_flash_model.sv
// Behavioural flash array that answers each start pulse with a done pulse
`timescale 1ns/100ps
`default_nettype none
module bfg_flash_model (
	// Clock and reset
	input wire logic mclk,
	input wire logic arst_n,
	// Array handshake
	input wire logic start,
	input wire logic [7:0] busyCycles,
	output logic done
);
	logic [7:0] left;
	// Count the programming time down, then pulse done for one cycle
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			left <= 8'h00;
			done <= 1'b0;
		end else begin
			done <= (left == 8'h01);
			if (start) begin
				left <= busyCycles;
			end else if (left != 8'h00) begin
				left <= left - 8'h01;
			end
		end
	end
endmodule
`default_nettype wire

// >>> tb/bfg_guard_tb_top.sv
// Self-checking bench for the boot flash section guard
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, e) begin total_checks++; if ((a) !== (e)) begin mismatches++; $display("unexpected at %0t: got %0h, expected %0h", $time, (a), (e)); end end
module bfg_guard_tb_top import bfg_pkg::*;;
	logic mclk, arst_n, vecInBoot, chipErase, progLockWr, lpmReq, flashDone, regWr, regRd;
	logic flashStart, flashErase, cpuHalt, rwwBlock, lpmGrant, lpmDeny, intDisable, irq;
	logic [1:0] bootSizeFuses;
	logic [3:0] lockNv, progLockData, regAddr;
	logic [7:0] regWdata, regRdata, busy;
	logic [BFG_AW-1:0] lpmPc, lpmAddr, curPc;
	logic [BFG_PG_AW-1:0] flashPage;
	bfg_spm_req_t store_program_memory_instr;
	int mismatches = 0;
	int total_checks = 0;

	bfg_guard uut (.mclk, .arst_n, .bootSizeFuses, .lockNv, .vecInBoot, .chipErase, .progLockWr,
		.progLockData, .store_program_memory_instr, .lpmReq, .lpmPc, .lpmAddr, .curPc, .flashDone, .flashStart, .flashErase,
		.flashPage, .cpuHalt, .rwwBlock, .lpmGrant, .lpmDeny, .intDisable, .irq, .regAddr, .regWdata,
		.regWr, .regRd, .regRdata);
	bfg_flash_model flash (.mclk, .arst_n, .start(flashStart), .busyCycles(busy), .done(flashDone));

	// Free-running core clock
	initial begin
		mclk = 1'b0;
		forever #4 mclk = ~mclk;
	end

	// Register bus cycles
	task automatic wr(input logic [3:0] a, input logic [7:0] v);
		regAddr <= a;
		regWdata <= v;
		regWr <= 1'b1;
		@(posedge mclk);
		regWr <= 1'b0;
		@(posedge mclk);
	endtask
	task automatic rd(input logic [3:0] a, input logic [7:0] e);
		regAddr <= a;
		regRd <= 1'b1;
		@(posedge mclk);
		regRd <= 1'b0;
		@(negedge mclk);
		`CHK(regRdata, e)
		@(posedge mclk);
	endtask

	// CPU store and load; results sampled in the answer cycle
	task automatic store(input bfg_op_t op, input logic [15:0] pc, ad, input logic [3:0] ld, output logic [12:0] r);
		store_program_memory_instr <= '{1'b1, op, pc, ad, ld};
		@(posedge mclk);
		store_program_memory_instr.valid <= 1'b0;
		@(negedge mclk);
		r = {flashStart, cpuHalt, rwwBlock, flashErase, flashPage};
		@(posedge mclk);
	endtask
	task automatic load(input logic [15:0] pc, ad, output logic [1:0] g);
		lpmReq <= 1'b1;
		lpmPc <= pc;
		lpmAddr <= ad;
		@(posedge mclk);
		lpmReq <= 1'b0;
		@(negedge mclk);
		g = {lpmGrant, lpmDeny};
		@(posedge mclk);
	endtask

	// Halt level is checked every cycle until the array reports done
	task automatic waitDone(input logic h);
		int n;
		n = 0;
		@(negedge mclk);
		while (flashDone !== 1'b1 && n < 300) begin
			`CHK(cpuHalt, h)
			n++;
			@(negedge mclk);
		end
		`CHK(n < 300, 1'b1)
		@(negedge mclk);
		`CHK(cpuHalt, 1'b0)
		@(posedge mclk);
	endtask

	task automatic t_rww();
		logic [12:0] r;
		logic [1:0] g;
		busy <= 8'h28;
		vecInBoot <= 1'b1; // Vectors stay in boot code while the concurrent region is busy
		store(BFG_OP_ERASE, 16'hFE00, 16'h1280, 4'hF, r);
		`CHK(r, {4'b1011, 9'h025})
		load(16'hFE00, 16'h0100, g);
		`CHK(g, 2'b01)
		load(16'hFE00, 16'hF800, g);
		`CHK(g, 2'b10)
		rd(BFG_REG_STATUS, 8'hF5);
		wr(BFG_REG_CTRL, 8'h01);
		store(BFG_OP_WRITE, 16'hFE00, 16'hFF00, 4'hF, r);
		`CHK(r[12:11], 2'b00)
		waitDone(1'b0);
		rd(BFG_REG_STATUS, 8'hF1);
		wr(BFG_REG_CTRL, 8'h01);
		rd(BFG_REG_STATUS, 8'hF0);
	endtask

	task automatic t_fuses();
		logic [12:0] r;
		logic [16:0] bs;
		busy <= 8'h03;
		for (int f = 0; f < 4; f++) begin
			bootSizeFuses <= 2'(f);
			bs = 17'h10000 - (BFG_BOOT_MIN_WORDS << (3 - f));
			@(posedge mclk);
			store(BFG_OP_WRITE, bs[15:0] - 16'h0001, 16'hFF80, 4'hF, r);
			`CHK(r[12], 1'b0)
			store(BFG_OP_WRITE, bs[15:0], 16'hFF80, 4'hF, r);
			`CHK(r[12:11], 2'b11)
			waitDone(1'b1);
		end
	endtask

	task automatic t_locks();
		logic [12:0] r;
		logic [1:0] g;
		logic [1:0] c;
		for (int k = 0; k < 4; k++) begin
			c = 2'(k);
			chipErase <= 1'b1;
			@(posedge mclk);
			chipErase <= 1'b0;
			progLockWr <= 1'b1;
			progLockData <= {c, c};
			@(posedge mclk);
			progLockWr <= 1'b0;
			@(posedge mclk);
			rd(BFG_REG_STATUS, {c, c, 4'h0});
			load(16'hFE00, 16'h0100, g);
			`CHK(g, {c[1], ~c[1]})
			load(16'h0010, 16'hFF00, g);
			`CHK(g, {c[1], ~c[1]})
			vecInBoot <= 1'b1;
			curPc <= 16'h0010;
			repeat (3) @(posedge mclk);
			`CHK(intDisable, ~c[1])
			vecInBoot <= 1'b0;
			curPc <= 16'hFE00;
			repeat (3) @(posedge mclk);
			`CHK(intDisable, ~c[1])
			store(BFG_OP_WRITE, 16'hFE00, 16'hFF00, 4'hF, r);
			`CHK(r[12:11], {c[0], c[0]})
			if (c[0]) waitDone(1'b1);
			store(BFG_OP_ERASE, 16'hFE00, 16'h0100, 4'hF, r);
			`CHK(r[12:10], {c[0], 1'b0, c[0]})
			if (c[0]) waitDone(1'b0);
			wr(BFG_REG_CTRL, 8'h01);
		end
		store(BFG_OP_LOCKSET, 16'hFE00, 16'h0000, 4'hE, r);
		progLockWr <= 1'b1;
		progLockData <= 4'hF;
		@(posedge mclk);
		progLockWr <= 1'b0;
		@(posedge mclk);
		rd(BFG_REG_STATUS, 8'hE0);
	endtask

	task automatic t_irq();
		logic [12:0] r;
		wr(BFG_REG_IRQ_CLR, 8'h0F);
		wr(BFG_REG_IRQ_EN, 8'h00);
		store(BFG_OP_WRITE, 16'h0010, 16'hFF00, 4'hF, r);
		`CHK(r[12], 1'b0)
		rd(BFG_REG_IRQ_STAT, 8'h04);
		`CHK(irq, 1'b0)
		wr(BFG_REG_IRQ_EN, 8'h04);
		rd(BFG_REG_IRQ_EN, 8'h04);
		`CHK(irq, 1'b1)
		wr(BFG_REG_IRQ_CLR, 8'h04);
		rd(BFG_REG_IRQ_STAT, 8'h00);
		`CHK(irq, 1'b0)
		store(BFG_OP_WRITE, 16'hFE00, 16'h0100, 4'hF, r);
		`CHK(r[12:10], 3'b000)
		store(BFG_OP_OTHER, 16'hFE00, 16'hFF00, 4'hF, r);
		`CHK(r[12:10], 3'b000)
		rd(BFG_REG_IRQ_STAT, 8'h02);
		rd(4'hF, 8'h00);
	endtask

	task automatic results();
		if (mismatches == 0 && total_checks > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask

	// Main sequence
	initial begin
		arst_n = 1'b0;
		bootSizeFuses = 2'b11;
		lockNv = 4'hF;
		vecInBoot = 1'b0;
		chipErase = 1'b0;
		progLockWr = 1'b0;
		progLockData = 4'h0;
		store_program_memory_instr = '0;
		lpmReq = 1'b0;
		lpmPc = 16'h0000;
		lpmAddr = 16'h0000;
		curPc = 16'hFE00;
		regAddr = 4'h0;
		regWdata = 8'h00;
		regWr = 1'b0;
		regRd = 1'b0;
		busy = 8'h03;
		repeat (16) @(posedge mclk);
		arst_n <= 1'b1;
		repeat (2) @(posedge mclk);
		t_rww();
		t_fuses();
		t_locks();
		t_irq();
		lockNv <= 4'h5;
		arst_n <= 1'b0;
		repeat (2) @(posedge mclk);
		`CHK({cpuHalt, rwwBlock, irq}, 3'b000)
		arst_n <= 1'b1;
		repeat (2) @(posedge mclk);
		rd(BFG_REG_STATUS, 8'h50);
		results();
	end

	// Watchdog against a hung handshake
	initial begin
		repeat (20000) @(posedge mclk);
		mismatches++;
		results();
	end
endmodule
`default_nettype wire
